// file: include/gain_format_pkg.sv
// Constants for the gain scaling and output format stage.
// Assumes a 32-bit AXI4-Lite register bus and a single 125 MHz clock.
package gain_format_pkg;
  localparam int IDX_CONFIG = 5;
  localparam int IDX_FRACTION = 6;
  localparam int IDX_EXPONENT = 7;
  localparam int IDX_FORMAT = 8;
  localparam int IDX_STANDBY = 9;
  localparam logic [7:0] ADDR_CONFIG = 8'(IDX_CONFIG * 4);
  localparam logic [7:0] ADDR_FRACTION = 8'(IDX_FRACTION * 4);
  localparam logic [7:0] ADDR_EXPONENT = 8'(IDX_EXPONENT * 4);
  localparam logic [7:0] ADDR_FORMAT = 8'(IDX_FORMAT * 4);
  localparam logic [7:0] ADDR_STANDBY = 8'(IDX_STANDBY * 4);
  localparam int EXP_W = 4;
  localparam int SYNC_BIT = 4;
  localparam int DETECT_OFF_BIT = 5;
  localparam int MONITOR_BIT = 6;
  localparam int STANDBY_BIT = 7;
  localparam int MUX_BIT = 0;
  localparam int POL_BIT = 1;
  localparam int SHAPE_BIT = 2;
  localparam int ROUND_TEN_BIT = 4;
  localparam int ROUND_TWELVE_BIT = 5;
  localparam int ROUND_FOURTEEN_BIT = 6;
  localparam int DECIM_W = 3;
  localparam int REAL_BIT = 4;
  localparam int POWER_DOWN_BIT = 7;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] FRACTION_RESET = 8'h00;
  localparam logic [7:0] EXPONENT_RESET = 8'h06;
  localparam logic [7:0] FORMAT_RESET = 8'h80;
  localparam logic [7:0] STANDBY_RESET = 8'h00;
  localparam logic [4:0] BASE_MAX = 5'h06;
  localparam logic [4:0] BASE_TOP = 5'h07;
  localparam int FRAC_SHIFT = 8;
  localparam int UNITY_SHIFT = 4;
  localparam int OUT_W = 16;
  localparam int OUT_LSB = FRAC_SHIFT + 6 - UNITY_SHIFT;
  localparam logic [4:0] DROP10 = 5'(OUT_LSB + 6);
  localparam logic [4:0] DROP12 = 5'(OUT_LSB + 4);
  localparam logic [4:0] DROP14 = 5'(OUT_LSB + 2);
  localparam logic [4:0] DROP16 = 5'(OUT_LSB);
  localparam logic [15:0] SAT_POS = 16'h7FFF;
  localparam logic [15:0] SAT_NEG = 16'h8000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam longint CLK_HZ = 125000000;
  localparam longint STANDBY_HZ = 1000;
  localparam int STANDBY_HALF = int'(CLK_HZ / (2 * STANDBY_HZ));
endpackage

// file: rtl/gain_format.sv
// Gain scaling, rounding and output word formatting with an AXI4-Lite slave.
// Assumes samples arrive on aclk with at least four cycles between them.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gain_format
  import gain_format_pkg::*;
#(
  parameter int IN_W = 12,
  parameter int PER_W = 8,
  parameter int STANDBY_HALF_CYCLES = STANDBY_HALF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic gain_sync_pin_n,
  input wire logic clock_lost,
  // Sample stream in
  input wire logic sample_valid,
  input wire logic signed [IN_W-1:0] sample_i,
  input wire logic signed [IN_W-1:0] sample_q,
  // Formatted output
  output logic [OUT_W-1:0] out_i,
  output logic [OUT_W-1:0] out_q,
  output logic inphase_marker,
  output logic word_strobe
);
  localparam int WIDE_W = IN_W + 32;
  localparam logic [PER_W-1:0] PER_MAX = '1;

  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] awaddr_q, wdata_q;
  logic wstrb_q;
  logic [7:0] config_q, fraction_q, format_q, standby_reg_q;
  logic [EXP_W-1:0] exponent_q;
  logic sync_gain_enable_q, clock_loss_detect_off_q;
  logic [7:0] shadow_frac_q, act_frac_q;
  logic [EXP_W-1:0] shadow_exp_q, act_exp_q;
  logic pending_q;
  logic sync_meta_q, sync_pin_q, cl_meta_q, cl_sync_q;
  logic standby_active_q, standby_clock_monitor_q;
  logic [31:0] div_q;
  logic [OUT_W-1:0] hold_i_q, hold_q_q, out_i_q, out_q_q;
  logic stg_q, i_half_q, marker_q, strobe_q;
  logic [PER_W-1:0] per_cnt_q, period_q, sl_q;

  // Register bus
  logic do_write, wr_hit, wr_exp, apply;
  logic [7:0] rd_val;
  logic rd_hit;
  assign do_write = !awready_q && !wready_q && !bvalid_q;
  assign wr_hit = awaddr_q == ADDR_CONFIG || awaddr_q == ADDR_FRACTION ||
                  awaddr_q == ADDR_EXPONENT || awaddr_q == ADDR_FORMAT ||
                  awaddr_q == ADDR_STANDBY;
  assign wr_exp = do_write && wstrb_q && awaddr_q == ADDR_EXPONENT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awready_q <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata[7:0];
        wstrb_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_q <= CONFIG_RESET;
      fraction_q <= FRACTION_RESET;
      exponent_q <= EXPONENT_RESET[EXP_W-1:0];
      sync_gain_enable_q <= EXPONENT_RESET[SYNC_BIT];
      clock_loss_detect_off_q <= EXPONENT_RESET[DETECT_OFF_BIT];
      format_q <= FORMAT_RESET;
      standby_reg_q <= STANDBY_RESET;
    end else if (do_write && wstrb_q) begin
      case (awaddr_q)
        ADDR_CONFIG: config_q <= wdata_q;
        ADDR_FRACTION: fraction_q <= wdata_q;
        ADDR_EXPONENT: begin
          exponent_q <= wdata_q[EXP_W-1:0];
          sync_gain_enable_q <= wdata_q[SYNC_BIT];
          clock_loss_detect_off_q <= wdata_q[DETECT_OFF_BIT];
        end
        ADDR_FORMAT: format_q <= wdata_q;
        ADDR_STANDBY: standby_reg_q <= wdata_q & (8'h01 << POWER_DOWN_BIT);
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      ADDR_CONFIG: rd_val = config_q;
      ADDR_FRACTION: rd_val = fraction_q;
      ADDR_EXPONENT: rd_val = {standby_active_q, standby_clock_monitor_q,
                               clock_loss_detect_off_q, sync_gain_enable_q, exponent_q};
      ADDR_FORMAT: rd_val = format_q;
      ADDR_STANDBY: rd_val = standby_reg_q;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_val};
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // Pin synchronisers and standby status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_meta_q <= 1'b1;
      sync_pin_q <= 1'b1;
      cl_meta_q <= 1'b0;
      cl_sync_q <= 1'b0;
    end else begin
      sync_meta_q <= gain_sync_pin_n;
      sync_pin_q <= sync_meta_q;
      cl_meta_q <= clock_lost;
      cl_sync_q <= cl_meta_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      standby_active_q <= 1'b0;
    end else begin
      standby_active_q <= standby_reg_q[POWER_DOWN_BIT] ||
                          (cl_sync_q && !clock_loss_detect_off_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 32'h0000_0000;
      standby_clock_monitor_q <= 1'b0;
    end else if (div_q >= 32'(STANDBY_HALF_CYCLES - 1)) begin
      div_q <= 32'h0000_0000;
      standby_clock_monitor_q <= !standby_clock_monitor_q;
    end else begin
      div_q <= div_q + 32'h0000_0001;
    end
  end

  // Double-buffered gain
  assign apply = pending_q && (!sync_gain_enable_q || !sync_pin_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shadow_frac_q <= FRACTION_RESET;
      shadow_exp_q <= EXPONENT_RESET[EXP_W-1:0];
      act_frac_q <= FRACTION_RESET;
      act_exp_q <= EXPONENT_RESET[EXP_W-1:0];
      pending_q <= 1'b0;
    end else begin
      if (apply) begin
        act_frac_q <= shadow_frac_q;
        act_exp_q <= shadow_exp_q;
      end
      if (wr_exp) begin
        shadow_frac_q <= fraction_q;
        shadow_exp_q <= wdata_q[EXP_W-1:0];
        pending_q <= 1'b1;
      end else if (apply) begin
        pending_q <= 1'b0;
      end
    end
  end

  // Scaling, rounding and saturation
  logic [DECIM_W-1:0] decimation_setting;
  logic [4:0] base_gain, shift, drop;
  assign decimation_setting = config_q[DECIM_W-1:0];
  assign base_gain = (decimation_setting <= 3'h1) ? BASE_MAX :
                     BASE_TOP - 5'(decimation_setting);
  assign shift = 5'(act_exp_q) + BASE_MAX - base_gain;
  assign drop = format_q[ROUND_TEN_BIT] ? DROP10 :
                format_q[ROUND_TWELVE_BIT] ? DROP12 :
                format_q[ROUND_FOURTEEN_BIT] ? DROP14 : DROP16;

  function automatic logic [OUT_W-1:0] scale(input logic signed [IN_W-1:0] x,
      input logic [7:0] f, input logic [4:0] e, input logic [4:0] d);
    logic signed [WIDE_W-1:0] w;
    logic signed [WIDE_W-1:0] top;
    logic [OUT_W-1:0] r;
    w = WIDE_W'(x * $signed({2'b01, f}));
    w = w <<< e;
    w = w + (WIDE_W'(1) <<< (d - 5'h01));
    top = w >>> (OUT_LSB + OUT_W - 1);
    if (top != '0 && top != '1) begin
      r = w[WIDE_W-1] ? SAT_NEG : SAT_POS;
    end else begin
      r = w[OUT_LSB +: OUT_W];
    end
    scale = r & (SAT_NEG | SAT_POS) << (d - 5'(OUT_LSB));
  endfunction

  // Output sequencing
  logic mux_on, pulse_mode, q_change, change, pulse_d, level_d;
  logic [PER_W-1:0] slot_len, sl_d;
  assign mux_on = format_q[MUX_BIT] && !config_q[REAL_BIT];
  assign pulse_mode = !format_q[SHAPE_BIT];
  assign slot_len = mux_on ? (period_q >> 1) : period_q;
  assign q_change = mux_on && i_half_q && !stg_q && sl_q == slot_len - PER_W'(1);
  assign change = stg_q || q_change;
  assign sl_d = change ? '0 : (sl_q == PER_MAX ? sl_q : sl_q + PER_W'(1));
  assign pulse_d = sample_valid ||
                   (mux_on && i_half_q && !stg_q && sl_q == slot_len - PER_W'(2));
  assign level_d = sl_d >= (slot_len >> 1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_cnt_q <= '0;
      period_q <= PER_MAX;
      stg_q <= 1'b0;
      hold_i_q <= '0;
      hold_q_q <= '0;
    end else begin
      stg_q <= sample_valid;
      if (sample_valid) begin
        per_cnt_q <= '0;
        period_q <= per_cnt_q == PER_MAX ? PER_MAX : per_cnt_q + PER_W'(1);
        hold_i_q <= scale(sample_i, act_frac_q, shift, drop);
        hold_q_q <= scale(sample_q, act_frac_q, shift, drop);
      end else if (per_cnt_q != PER_MAX) begin
        per_cnt_q <= per_cnt_q + PER_W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_i_q <= '0;
      out_q_q <= '0;
      marker_q <= 1'b0;
      i_half_q <= 1'b0;
      sl_q <= '0;
      strobe_q <= 1'b0;
    end else begin
      sl_q <= sl_d;
      strobe_q <= (pulse_mode ? pulse_d : level_d) ^ format_q[POL_BIT];
      if (standby_active_q) begin
        out_i_q <= '0;
        out_q_q <= '0;
        marker_q <= 1'b0;
        i_half_q <= 1'b0;
        strobe_q <= format_q[POL_BIT];
      end else if (stg_q) begin
        out_i_q <= hold_i_q;
        out_q_q <= mux_on ? '0 : hold_q_q;
        marker_q <= mux_on;
        i_half_q <= mux_on;
      end else if (q_change) begin
        out_i_q <= hold_q_q;
        out_q_q <= '0;
        marker_q <= 1'b0;
        i_half_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign out_i = out_i_q;
  assign out_q = out_q_q;
  assign inphase_marker = marker_q;
  assign word_strobe = strobe_q;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_FRACTION_STORE: assert property (
    do_write && wstrb_q && awaddr_q == ADDR_FRACTION |=> fraction_q == $past(wdata_q))
    else $error("fraction register did not take the write");
  AST_EXPONENT_STORE: assert property (
    wr_exp |=> exponent_q == $past(wdata_q[EXP_W-1:0]))
    else $error("exponent register did not take the write");
  AST_BASE_GAIN: assert property (
    decimation_setting >= 3'h1 |-> base_gain + 5'(decimation_setting) == BASE_TOP)
    else $error("base gain wrong for decimation setting");
  AST_APPLY_DIRECT: assert property (
    wr_exp && !sync_gain_enable_q ##1 !sync_gain_enable_q && !wr_exp
    |=> act_exp_q == $past(wdata_q[EXP_W-1:0], 2))
    else $error("gain not applied after exponent write");
  AST_SYNC_HOLD: assert property (
    sync_gain_enable_q && sync_pin_q |=> $stable(act_exp_q) && $stable(act_frac_q))
    else $error("gain changed before sync pin went low");
  AST_FRACTION_ONLY: assert property (
    !pending_q && !wr_exp |=> $stable(act_frac_q))
    else $error("fraction applied without exponent write");
  AST_MUX_Q_LOW: assert property (
    mux_on && stg_q |=> out_q == '0 && (inphase_marker || $past(standby_active_q)))
    else $error("Q port not low or marker missing in multiplex mode");
  AST_STROBE_PULSE: assert property (
    pulse_mode && $stable(format_q) && !standby_active_q && sample_valid
    |=> word_strobe != format_q[POL_BIT])
    else $error("word strobe missing before output change");
  AST_ROUND_CLEAR: assert property (
    format_q[ROUND_TEN_BIT] && $stable(format_q) && sample_valid |=> hold_i_q[5:0] == 6'h00)
    else $error("low bits not cleared for ten-bit rounding");
  AST_STANDBY_FLAG: assert property (
    standby_reg_q[POWER_DOWN_BIT] |=> standby_active_q)
    else $error("standby flag not set by power-down");
  AST_STANDBY_QUIET: assert property (
    standby_active_q |=> out_i == '0 && out_q == '0 && !inphase_marker &&
    word_strobe == $past(format_q[POL_BIT]))
    else $error("outputs not quiet in standby");
  AST_Q_STROBE: assert property (
    q_change && pulse_mode && $stable(format_q) |-> word_strobe != format_q[POL_BIT])
    else $error("word strobe missing before Q word");
endmodule
`default_nettype wire

// file: dv/sample_sink.sv
// Downstream sink model: takes each formatted word one cycle after its strobe.
// Assumes the bench tells it the strobe polarity in use.
`timescale 1ns/1ps
`default_nettype none
module sample_sink (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Formatted stream
  input wire logic [15:0] out_i,
  input wire logic [15:0] out_q,
  input wire logic word_strobe,
  input wire logic strobe_polarity,
  // Last words taken
  output logic [15:0] got_i,
  output logic [15:0] got_q
);
  logic seen_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_q <= 1'b0;
      got_i <= 16'h0000;
      got_q <= 16'h0000;
    end else begin
      seen_q <= word_strobe ^ strobe_polarity;
      if (seen_q) begin
        got_i <= out_i;
        got_q <= out_q;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the gain and output format stage.
// Assumes the sink model is compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gain_format_pkg::*;
  typedef struct {logic [7:0] fmt; logic [2:0] decim; logic [7:0] ex;
    logic [7:0] fr; logic [11:0] x; logic [15:0] y;} row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic gain_sync_pin_n = 1'b1;
  logic clock_lost = 1'b0;
  logic sample_valid = 1'b0;
  logic signed [11:0] sample_i = 12'h000;
  logic signed [11:0] sample_q = 12'h000;
  logic [15:0] out_i, out_q, oi, oq, sink_i, sink_q;
  logic inphase_marker, word_strobe, mk, sw;
  logic pol = 1'b0;
  logic [7:0] rdat, n_hi, ka_or, ka_and;
  logic [1:0] resp;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  row_t rows[17] = '{'{8'h80,3'h0,8'h06,8'h00,12'h123,16'h1230},
    '{8'h80,3'h1,8'h06,8'h00,12'hFFF,16'hFFF0}, '{8'h80,3'h2,8'h05,8'h00,12'h7FF,16'h7FF0},
    '{8'h80,3'h3,8'h04,8'h00,12'h800,16'h8000}, '{8'h80,3'h4,8'h03,8'h00,12'h001,16'h0010},
    '{8'h80,3'h5,8'h02,8'h00,12'h456,16'h4560}, '{8'h80,3'h6,8'h01,8'h00,12'h0AB,16'h0AB0},
    '{8'h80,3'h7,8'h00,8'h00,12'h100,16'h1000}, '{8'h80,3'h0,8'h06,8'h80,12'h100,16'h1800},
    '{8'h80,3'h0,8'h07,8'h00,12'h100,16'h2000}, '{8'h80,3'h0,8'h05,8'h00,12'h101,16'h0808},
    '{8'h80,3'h0,8'h06,8'h01,12'h123,16'h1242}, '{8'h40,3'h0,8'h06,8'h01,12'h123,16'h1244},
    '{8'h20,3'h0,8'h06,8'h01,12'h123,16'h1240}, '{8'h10,3'h0,8'h06,8'h01,12'h123,16'h1240},
    '{8'h80,3'h7,8'h0F,8'h00,12'h100,16'h7FFF}, '{8'h80,3'h7,8'h0F,8'h00,12'h800,16'h8000}};
  logic [7:0] sfmt[4] = '{8'h80, 8'h82, 8'h84, 8'h86};
  logic [7:0] scnt[4] = '{8'h01, 8'h07, 8'h04, 8'h04};

  gain_format #(.STANDBY_HALF_CYCLES(4)) gain_format_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gain_sync_pin_n, .clock_lost,
    .sample_valid, .sample_i, .sample_q, .out_i, .out_q, .inphase_marker, .word_strobe);
  sample_sink sample_sink_i (.aclk, .aresetn, .out_i, .out_q, .word_strobe,
    .strobe_polarity(pol), .got_i(sink_i), .got_q(sink_q));

  always #4 aclk = ~aclk;

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Bus tasks are entered just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic done;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    logic done;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        rdat = s_axi_rdata[7:0];
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge aclk);
  endtask

  // One sample, then eight cycles of strobe counting; spacing is 8
  task automatic smp(input logic [11:0] i, input logic [11:0] q);
    sample_valid <= 1'b1;
    sample_i <= i;
    sample_q <= q;
    n_hi = 8'h00;
    for (int k = 0; k < 8; k++) begin
      #1;
      n_hi = n_hi + {7'h0, word_strobe};
      if (k == 3) begin
        oi = out_i;
        oq = out_q;
        mk = inphase_marker;
        sw = word_strobe;
      end
      @(posedge aclk);
      if (k == 0) sample_valid <= 1'b0;
    end
  endtask

  // Fraction first, then exponent
  task automatic setg(input logic [2:0] d, input logic [7:0] e, input logic [7:0] f,
      input logic [7:0] m);
    wr(ADDR_CONFIG, {5'h0, d});
    wr(ADDR_FORMAT, m);
    wr(ADDR_FRACTION, f);
    wr(ADDR_EXPONENT, e);
    repeat (3) @(posedge aclk);
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ADDR_EXPONENT);
    chk8(rdat & 8'h3F, 8'h06);
    rd(ADDR_FORMAT);
    chk8(rdat, 8'h80);
    wr(ADDR_FRACTION, 8'hA5);
    rd(ADDR_FRACTION);
    chk8(rdat, 8'hA5);
    wr(ADDR_EXPONENT, 8'hCB);
    rd(ADDR_EXPONENT);
    chk8(rdat & 8'hBF, 8'h0B);
    rd(8'h3C);
    chk8({6'h0, resp}, {6'h0, RESP_SLVERR});
    wr(8'h3C, 8'h11);
    chk8({6'h0, resp}, {6'h0, RESP_SLVERR});
    $display("registers done");
    for (int n = 0; n < 17; n++) begin
      setg(rows[n].decim, rows[n].ex, rows[n].fr, rows[n].fmt);
      smp(rows[n].x, rows[n].x);
      chk16(oi, rows[n].y);
      chk16(oq, rows[n].y);
      chk16(sink_i, rows[n].y);
      chk8(n_hi, 8'h01);
    end
    $display("gain rows done");
    setg(3'h0, 8'h06, 8'h00, 8'h80);
    wr(ADDR_FRACTION, 8'h80);
    smp(12'h100, 12'h100);
    chk16(oi, 16'h1000);
    wr(ADDR_EXPONENT, 8'h17);
    smp(12'h100, 12'h100);
    chk16(oi, 16'h1000);
    gain_sync_pin_n <= 1'b0;
    repeat (4) @(posedge aclk);
    gain_sync_pin_n <= 1'b1;
    repeat (2) @(posedge aclk);
    smp(12'h100, 12'h100);
    chk16(oi, 16'h3000);
    $display("sync gain done");
    setg(3'h0, 8'h06, 8'h00, 8'h80);
    for (int n = 0; n < 4; n++) begin
      wr(ADDR_FORMAT, sfmt[n]);
      pol <= sfmt[n][POL_BIT];
      repeat (3) smp(12'h010, 12'h020);
      chk8(n_hi, scnt[n]);
      chk8({7'h0, sw}, {7'h0, sfmt[n][POL_BIT]});
    end
    $display("strobe shapes done");
    wr(ADDR_FORMAT, 8'h81);
    pol <= 1'b0;
    repeat (3) smp(12'h123, 12'h456);
    chk16(oi, 16'h1230);
    chk8({7'h0, mk}, 8'h01);
    chk16(oq, 16'h0000);
    chk8(n_hi, 8'h02);
    #1;
    chk16(out_i, 16'h4560);
    chk8({7'h0, inphase_marker}, 8'h00);
    chk16(sink_q, 16'h0000);
    @(posedge aclk);
    wr(ADDR_CONFIG, 8'(1 << REAL_BIT));
    smp(12'h123, 12'h456);
    chk16(oq, 16'h4560);
    chk8({7'h0, mk}, 8'h00);
    wr(ADDR_CONFIG, 8'h00);
    $display("multiplex done");
    wr(ADDR_FORMAT, 8'h80);
    wr(ADDR_STANDBY, 8'h80);
    ka_or = 8'h00;
    ka_and = 8'hFF;
    repeat (5) begin
      rd(ADDR_EXPONENT);
      ka_or = ka_or | rdat;
      ka_and = ka_and & rdat;
    end
    chk8(ka_and & 8'h80, 8'h80);
    chk8((ka_or ^ ka_and) & 8'h40, 8'h40);
    smp(12'h123, 12'h123);
    chk16(oi, 16'h0000);
    wr(ADDR_STANDBY, 8'h00);
    rd(ADDR_EXPONENT);
    chk8(rdat & 8'hBF, 8'h06);
    smp(12'h123, 12'h123);
    chk16(oi, 16'h1230);
    clock_lost <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(ADDR_EXPONENT);
    chk8(rdat & 8'hBF, 8'h86);
    wr(ADDR_EXPONENT, 8'h26);
    repeat (4) @(posedge aclk);
    rd(ADDR_EXPONENT);
    chk8(rdat & 8'hBF, 8'h26);
    clock_lost <= 1'b0;
    $display("standby done");
    wr(ADDR_FRACTION, 8'h5A);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ADDR_FRACTION);
    chk8(rdat, 8'h00);
    rd(ADDR_EXPONENT);
    chk8(rdat & 8'h3F, 8'h06);
    $display("reset done");
    stop_test();
  end
endmodule
`default_nettype wire
